/* File: design/ddc_chan_ctrl.sv */
//
// Function
// - soft-reset bit set holds the NCO in reset; clearing it resumes
// - sync mode: 00 ignores sync input, 01 resyncs on every sync event
// - mixer-select zero gives a real mixer, one a complex mixer
// - gain-select zero gives no gain, one gives six decibels
// - IF code 00: variable IF, mixers and NCO active
// - IF code 01: zero-hertz IF, mixer bypassed, NCO keeps running but its phase is unused
// - IF code 10: downmix by a fixed quarter of sample rate
// - IF code 11: mixer inputs forced to positive full scale, NCO on
// - complex-to-real bit one makes output real, zero keeps it complex
// - without complex-to-real, code 11 decimates by two, 00 by four
// - with complex-to-real, ratios halve: 11 is one, highest is eight
// - I and Q inputs each pick channel A or B by own select bit
//
`timescale 1ns/100ps
`include "ddc_regs.svh"

module ddc_chan_ctrl #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              sync_in,
   input  wire logic [11:0]       nco_ftw,
   input  wire logic              samp_valid,
   output logic                   samp_ready,
   input  wire ddc_pkg::ddc_adc_t samp_data,
   output logic                   out_valid,
   input  wire logic              out_ready,
   output ddc_pkg::ddc_out_t      out_data
);

   ddc_pkg::ddc_sync_cfg_t sync_q;
   ddc_pkg::ddc_cfg_t      cfg_q;
   ddc_pkg::ddc_insel_t    insel_q;
   ddc_pkg::ddc_nco_st_t   nco_st_q;
   ddc_pkg::ddc_nco_st_t   nco_st_d;
   ddc_pkg::ddc_iq_t       sel;
   ddc_pkg::ddc_out_t      s1_q;
   logic [31:0]            prdata_q;
   logic [9:0]             idx;
   logic                   hit;
   logic                   wr_en;
   logic                   sync_wr;
   logic                   resync;
   logic [11:0]            phase_q;
   logic [1:0]             qtr_q;
   logic [1:0]             quad;
   logic [4:0]             ratio;
   logic [4:0]             dec_cnt_q;
   logic                   keep;
   logic                   load;
   logic                   s1_vld_q;
   logic                   fifo_in_ready;
   logic signed [15:0]     ext_i;
   logic signed [15:0]     ext_q;
   logic signed [15:0]     rot_i;
   logic signed [15:0]     rot_q;

   // reset words as typed constants so their fields can be sliced
   localparam logic [7:0]  RST_SYNC  = `DDC_RST_SYNC;
   localparam logic [7:0]  RST_CTRL  = `DDC_RST_CTRL;
   localparam logic [7:0]  RST_INSEL = `DDC_RST_INSEL;

   ////////////////////////////////////////////////////////////////////////////
   // decimation ratio lookup
   function automatic logic [4:0] ddc_ratio(input logic [1:0] code,
                                            input logic       c2r);
      logic [4:0] base;
      base = 5'h04;
      unique case (code)
         2'h3: base = 5'h02;
         2'h0: base = 5'h04;
         2'h1: base = 5'h08;
         2'h2: base = 5'h10;
      endcase
      // real output halves every ratio
      return c2r ? (base >> 1) : base;
   endfunction : ddc_ratio

   ////////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states
   assign idx     = paddr[11:2];
   assign hit     = (paddr[1:0] == 2'h0) &&
                    (idx == `DDC_IDX_SYNC || idx == `DDC_IDX_CTRL ||
                     idx == `DDC_IDX_INSEL || idx == `DDC_IDX_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign wr_en   = psel && penable && pwrite && hit;
   assign sync_wr = wr_en && (idx == `DDC_IDX_SYNC);
   assign prdata  = prdata_q;

   // config registers, written at the access edge
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync_q  <= ddc_pkg::ddc_sync_cfg_t'({RST_SYNC[4], RST_SYNC[1:0]});
         cfg_q   <= ddc_pkg::ddc_cfg_t'({RST_CTRL[7:3], RST_CTRL[1:0]});
         insel_q <= ddc_pkg::ddc_insel_t'({RST_INSEL[2], RST_INSEL[0]});
      end
      else if (wr_en)
      begin
         if (idx == `DDC_IDX_SYNC)
         begin
            sync_q.nco_rst <= pwdata[`DDC_SYNC_NRST_BIT];
            sync_q.mode    <= ddc_pkg::ddc_sync_mode_t'(pwdata[`DDC_SYNC_MODE_LSB +: 2]);
         end
         if (idx == `DDC_IDX_CTRL)
         begin
            cfg_q.cplx_mix <= pwdata[`DDC_CTRL_MIX_BIT];
            cfg_q.gain6    <= pwdata[`DDC_CTRL_GAIN_BIT];
            cfg_q.if_mode  <= ddc_pkg::ddc_if_mode_t'(pwdata[`DDC_CTRL_IF_LSB +: 2]);
            cfg_q.c2r      <= pwdata[`DDC_CTRL_C2R_BIT];
            cfg_q.dec_code <= pwdata[`DDC_CTRL_DEC_LSB +: 2];
         end
         if (idx == `DDC_IDX_INSEL)
         begin
            insel_q.q_from_b <= pwdata[`DDC_INSEL_Q_BIT];
            insel_q.i_from_b <= pwdata[`DDC_INSEL_I_BIT];
         end
      end
   end

   // read data captured in the setup phase, shown in the access phase
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         prdata_q <= 32'h0000_0000;
         unique case (idx)
            `DDC_IDX_SYNC:
            begin
               prdata_q[`DDC_SYNC_NRST_BIT]      <= sync_q.nco_rst;
               prdata_q[`DDC_SYNC_MODE_LSB +: 2] <= sync_q.mode;
            end
            `DDC_IDX_CTRL:
            begin
               prdata_q[`DDC_CTRL_MIX_BIT]      <= cfg_q.cplx_mix;
               prdata_q[`DDC_CTRL_GAIN_BIT]     <= cfg_q.gain6;
               prdata_q[`DDC_CTRL_IF_LSB +: 2]  <= cfg_q.if_mode;
               prdata_q[`DDC_CTRL_C2R_BIT]      <= cfg_q.c2r;
               prdata_q[`DDC_CTRL_DEC_LSB +: 2] <= cfg_q.dec_code;
            end
            `DDC_IDX_INSEL:
            begin
               prdata_q[`DDC_INSEL_Q_BIT] <= insel_q.q_from_b;
               prdata_q[`DDC_INSEL_I_BIT] <= insel_q.i_from_b;
            end
            `DDC_IDX_STAT:
            begin
               prdata_q[`DDC_STAT_ST_LSB +: 3]  <= nco_st_q;
               prdata_q[`DDC_STAT_RAT_LSB +: 5] <= ratio;
               prdata_q[`DDC_STAT_PEND_BIT]     <= s1_vld_q;
            end
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nco state: held, armed for one sync, or free running
   always_comb
   begin
      nco_st_d = nco_st_q;
      unique case (nco_st_q)
         ddc_pkg::DDC_NCO_HOLD:
            if (!sync_q.nco_rst)
               nco_st_d = (sync_q.mode == ddc_pkg::DDC_SYNC_ONCE) ?
                          ddc_pkg::DDC_NCO_WAIT : ddc_pkg::DDC_NCO_FREE;
         ddc_pkg::DDC_NCO_WAIT:
            if (sync_in)
               nco_st_d = ddc_pkg::DDC_NCO_FREE;
         ddc_pkg::DDC_NCO_FREE:
            if (sync_wr && pwdata[`DDC_SYNC_MODE_LSB +: 2] == ddc_pkg::DDC_SYNC_ONCE)
               nco_st_d = ddc_pkg::DDC_NCO_WAIT;
         default: nco_st_d = ddc_pkg::DDC_NCO_HOLD;
      endcase
      // soft reset overrides everything
      if (sync_q.nco_rst)
      begin
         nco_st_d = ddc_pkg::DDC_NCO_HOLD;
      end
      else if (nco_st_q == ddc_pkg::DDC_NCO_WAIT &&
               sync_q.mode != ddc_pkg::DDC_SYNC_ONCE)
      begin
         nco_st_d = ddc_pkg::DDC_NCO_FREE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         nco_st_q <= ddc_pkg::DDC_NCO_HOLD;
      end
      else
      begin
         nco_st_q <= nco_st_d;
      end
   end

   // resync pulse; reserved mode code behaves as disabled
   assign resync = sync_in &&
                   ((sync_q.mode == ddc_pkg::DDC_SYNC_CONT &&
                     nco_st_q == ddc_pkg::DDC_NCO_FREE) ||
                    (sync_q.mode == ddc_pkg::DDC_SYNC_ONCE &&
                     nco_st_q == ddc_pkg::DDC_NCO_WAIT));

   // phase accumulator and quarter-rate counter advance per sample
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         phase_q <= 12'h000;
         qtr_q   <= 2'h0;
      end
      else if (nco_st_q == ddc_pkg::DDC_NCO_HOLD || sync_q.nco_rst || resync)
      begin
         phase_q <= 12'h000;
         qtr_q   <= 2'h0;
      end
      else if (load)
      begin
         phase_q <= phase_q + nco_ftw;
         qtr_q   <= qtr_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input select and test forcing
   always_comb
   begin
      sel.i = insel_q.i_from_b ? samp_data.b : samp_data.a;
      sel.q = insel_q.q_from_b ? samp_data.b : samp_data.a;
      if (cfg_q.if_mode == ddc_pkg::DDC_IF_TEST)
      begin
         sel.i = `DDC_POS_FULL_SCALE;
         sel.q = `DDC_POS_FULL_SCALE;
      end
   end

   // real mixer sees no quadrature input
   assign ext_i = 16'(sel.i);
   assign ext_q = cfg_q.cplx_mix ? 16'(sel.q) : 16'h0000;

   // rotation quadrant; coarse nco uses top phase bits only
   always_comb
   begin
      unique case (cfg_q.if_mode)
         ddc_pkg::DDC_IF_VAR:  quad = phase_q[11:10];
         ddc_pkg::DDC_IF_ZERO: quad = 2'h0;
         ddc_pkg::DDC_IF_QTR:  quad = qtr_q;
         ddc_pkg::DDC_IF_TEST: quad = phase_q[11:10];
      endcase
   end

   // multiply by e^-j(quad*90deg); widened first so negation cannot wrap
   always_comb
   begin
      rot_i = ext_i;
      rot_q = ext_q;
      unique case (quad)
         2'h0:
         begin
            rot_i = ext_i;
            rot_q = ext_q;
         end
         2'h1:
         begin
            rot_i = ext_q;
            rot_q = -ext_i;
         end
         2'h2:
         begin
            rot_i = -ext_i;
            rot_q = -ext_q;
         end
         2'h3:
         begin
            rot_i = -ext_q;
            rot_q = ext_i;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // decimation: keep the last sample of each group
   assign ratio = ddc_ratio(cfg_q.dec_code, cfg_q.c2r);
   assign keep  = (dec_cnt_q >= ratio - 5'h01);
   assign load  = samp_valid && samp_ready;

   // stalls only while a kept sample waits for fifo room
   assign samp_ready = !s1_vld_q || fifo_in_ready;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         dec_cnt_q <= 5'h00;
      end
      else if (resync)
      begin
         dec_cnt_q <= 5'h00;
      end
      else if (load)
      begin
         dec_cnt_q <= keep ? 5'h00 : dec_cnt_q + 5'h01;
      end
   end

   // output stage: gain, then complex or real form
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         s1_q     <= '0;
         s1_vld_q <= 1'b0;
      end
      else if (load && keep)
      begin
         s1_vld_q   <= 1'b1;
         s1_q.i     <= cfg_q.gain6 ? (rot_i <<< 1) : rot_i;
         s1_q.q     <= cfg_q.c2r ? 16'h0000 :
                       (cfg_q.gain6 ? (rot_q <<< 1) : rot_q);
         s1_q.is_real <= cfg_q.c2r;
      end
      else if (fifo_in_ready)
      begin
         s1_vld_q <= 1'b0;
      end
   end

   ddc_fifo #(
      .W     ($bits(ddc_pkg::ddc_out_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (s1_vld_q),
      .in_ready  (fifo_in_ready),
      .in_data   (s1_q),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_once_fire;
      nco_st_q == ddc_pkg::DDC_NCO_WAIT && sync_in && !sync_q.nco_rst;
   endsequence

   property p_nco_hold;
      @(posedge clk) disable iff (!nrst)
      sync_q.nco_rst |=> nco_st_q == ddc_pkg::DDC_NCO_HOLD && phase_q == 12'h000;
   endproperty
   a_nco_hold: assert property (p_nco_hold)
      else $error("nco not held in soft reset");

   property p_sync_off;
      @(posedge clk) disable iff (!nrst)
      sync_q.mode == ddc_pkg::DDC_SYNC_OFF |-> !resync;
   endproperty
   a_sync_off: assert property (p_sync_off)
      else $error("sync acted while disabled");

   property p_sync_cont;
      @(posedge clk) disable iff (!nrst)
      sync_in && sync_q.mode == ddc_pkg::DDC_SYNC_CONT &&
      nco_st_q == ddc_pkg::DDC_NCO_FREE |=> phase_q == 12'h000 && dec_cnt_q == 5'h00;
   endproperty
   a_sync_cont: assert property (p_sync_cont)
      else $error("continuous sync did not realign");

   property p_once;
      @(posedge clk) disable iff (!nrst)
      s_once_fire |=> nco_st_q == ddc_pkg::DDC_NCO_FREE ##1
                      (!resync || sync_q.mode != ddc_pkg::DDC_SYNC_ONCE ||
                       nco_st_q == ddc_pkg::DDC_NCO_WAIT);
   endproperty
   a_once: assert property (p_once)
      else $error("one-shot sync fired twice");

   property p_real_mix;
      @(posedge clk) disable iff (!nrst)
      !cfg_q.cplx_mix |-> ext_q == 16'h0000;
   endproperty
   a_real_mix: assert property (p_real_mix)
      else $error("real mixer saw quadrature input");

   property p_gain;
      @(posedge clk) disable iff (!nrst)
      load && keep |=> s1_q.i == ($past(cfg_q.gain6) ? $past(rot_i) <<< 1 : $past(rot_i));
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain not applied as selected");

   property p_zero_if;
      @(posedge clk) disable iff (!nrst)
      cfg_q.if_mode == ddc_pkg::DDC_IF_ZERO |-> rot_i == ext_i && rot_q == ext_q;
   endproperty
   a_zero_if: assert property (p_zero_if)
      else $error("zero IF mode rotated samples");

   property p_qtr;
      @(posedge clk) disable iff (!nrst)
      load && !resync && !sync_q.nco_rst && nco_st_q != ddc_pkg::DDC_NCO_HOLD
      |=> qtr_q == 2'($past(qtr_q) + 2'h1);
   endproperty
   a_qtr: assert property (p_qtr)
      else $error("quarter rate counter did not step");

   property p_test;
      @(posedge clk) disable iff (!nrst)
      cfg_q.if_mode == ddc_pkg::DDC_IF_TEST |-> sel.i == `DDC_POS_FULL_SCALE;
   endproperty
   a_test: assert property (p_test)
      else $error("test mode input not full scale");

   property p_c2r;
      @(posedge clk) disable iff (!nrst)
      load && keep && cfg_q.c2r |=> s1_q.is_real && s1_q.q == 16'h0000;
   endproperty
   a_c2r: assert property (p_c2r)
      else $error("real output carried quadrature");

   property p_dec_two;
      @(posedge clk) disable iff (!nrst)
      cfg_q.dec_code == 2'h3 |-> ratio == (cfg_q.c2r ? 5'h01 : 5'h02);
   endproperty
   a_dec_two: assert property (p_dec_two)
      else $error("code 11 ratio wrong");

   property p_dec_bound;
      @(posedge clk) disable iff (!nrst)
      load |=> dec_cnt_q < $past(ratio);
   endproperty
   a_dec_bound: assert property (p_dec_bound)
      else $error("decimation counter overran ratio");

   property p_insel;
      @(posedge clk) disable iff (!nrst)
      insel_q.i_from_b && cfg_q.if_mode != ddc_pkg::DDC_IF_TEST |-> sel.i == samp_data.b;
   endproperty
   a_insel: assert property (p_insel)
      else $error("I input not from channel B");

endmodule : ddc_chan_ctrl

/* File: design/ddc_fifo.sv */
`timescale 1ns/100ps

module ddc_fifo #(
   parameter int W     = 33,
   parameter int DEPTH = 4
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   // extra pointer bit tells full from empty
   assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q[AW-1:0]];

   // storage, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule : ddc_fifo

/* File: design/ddc_pkg.sv */
package ddc_pkg;

   typedef enum logic [1:0] {
      DDC_IF_VAR  = 2'h0,
      DDC_IF_ZERO = 2'h1,
      DDC_IF_QTR  = 2'h2,
      DDC_IF_TEST = 2'h3
   } ddc_if_mode_t;

   typedef enum logic [1:0] {
      DDC_SYNC_OFF  = 2'h0,
      DDC_SYNC_CONT = 2'h1,
      DDC_SYNC_ONCE = 2'h2,
      DDC_SYNC_RSVD = 2'h3
   } ddc_sync_mode_t;

   typedef enum logic [2:0] {
      DDC_NCO_HOLD = 3'b001,
      DDC_NCO_WAIT = 3'b010,
      DDC_NCO_FREE = 3'b100
   } ddc_nco_st_t;

   typedef struct packed {
      logic           nco_rst;
      ddc_sync_mode_t mode;
   } ddc_sync_cfg_t;

   typedef struct packed {
      logic         cplx_mix;
      logic         gain6;
      ddc_if_mode_t if_mode;
      logic         c2r;
      logic [1:0]   dec_code;
   } ddc_cfg_t;

   typedef struct packed {
      logic q_from_b;
      logic i_from_b;
   } ddc_insel_t;

   // one converter sample per channel
   typedef struct packed {
      logic signed [13:0] a;
      logic signed [13:0] b;
   } ddc_adc_t;

   typedef struct packed {
      logic signed [13:0] i;
      logic signed [13:0] q;
   } ddc_iq_t;

   typedef struct packed {
      logic               is_real;
      logic signed [15:0] i;
      logic signed [15:0] q;
   } ddc_out_t;

endpackage : ddc_pkg

/* File: design/ddc_regs.svh */
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// register word indices; byte address is four times the index
`define DDC_IDX_SYNC       10'h300
`define DDC_IDX_CTRL       10'h310
`define DDC_IDX_INSEL      10'h311
`define DDC_IDX_STAT       10'h3f0

// reset values
`define DDC_RST_SYNC       8'h00
`define DDC_RST_CTRL       8'h00
`define DDC_RST_INSEL      8'h00

// sync control fields
`define DDC_SYNC_NRST_BIT  4
`define DDC_SYNC_MODE_LSB  0

// channel control fields
`define DDC_CTRL_MIX_BIT   7
`define DDC_CTRL_GAIN_BIT  6
`define DDC_CTRL_IF_LSB    4
`define DDC_CTRL_C2R_BIT   3
`define DDC_CTRL_DEC_LSB   0

// input select fields
`define DDC_INSEL_Q_BIT    2
`define DDC_INSEL_I_BIT    0

// status fields
`define DDC_STAT_ST_LSB    0
`define DDC_STAT_RAT_LSB   4
`define DDC_STAT_PEND_BIT  12

// test level for mixer inputs
`define DDC_POS_FULL_SCALE 14'h1fff

`endif

/* File: test/ddc_sink.sv */
`timescale 1ns/100ps

// downstream receiver; stall holds off the block's output like a slow consumer
module ddc_sink (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              stall,
   input  wire logic              out_valid,
   output logic                   out_ready,
   input  wire ddc_pkg::ddc_out_t out_data,
   output logic [7:0]             cnt_q,
   output ddc_pkg::ddc_out_t      last_q
);
   assign out_ready = !stall;

   // count each popped word; only the last one is kept to save space
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_q  <= 8'h00;
         last_q <= '0;
      end
      else if (out_valid && out_ready)
      begin
         cnt_q  <= cnt_q + 8'h01;
         last_q <= out_data;
      end
   end
endmodule : ddc_sink

/* File: test/ddc_sync_and_channel_control_tb.sv */
`timescale 1ns/100ps
`include "ddc_regs.svh"

module ddc_sync_and_channel_control_tb;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0000_0000;
   logic [31:0]       prdata;
   logic              pready, pslverr, samp_ready, out_valid, out_ready, er;
   logic              sync_in = 1'b0;
   logic              samp_valid = 1'b0;
   logic              stall = 1'b0;
   logic [11:0]       nco_ftw = 12'h000;
   ddc_pkg::ddc_adc_t samp_data = '0;
   ddc_pkg::ddc_out_t out_data, last;
   logic [7:0]        cnt, c0;
   logic [31:0]       rd;
   logic [4:0]        rt [4] = '{5'h04, 5'h08, 5'h10, 5'h02};
   int                failures = 0;
   int                n_checks = 0;
   int                k;

   always #5 clk = ~clk;

   ddc_chan_ctrl #(.FIFO_DEPTH(4)) u_dut (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .nco_ftw(nco_ftw),
      .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_data(samp_data),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   ddc_sink u_sink (.clk(clk), .nrst(nrst), .stall(stall), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .cnt_q(cnt), .last_q(last));

   ////////////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   task chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // bounded waits only; a hang ends the run with a mismatch
   task tmo(input string nm);
      failures++;
      $display("[FAIL] %s expected done seen timeout", nm);
      close_out();
   endtask : tmo

   // apb master: request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         tmo("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rchk(input string nm, input logic [9:0] idx, input logic [31:0] exp, input logic e);
      apb(1'b0, idx, 32'h0000_0000);
      chk(nm, {1'b0, rd}, {1'b0, exp});
      chk("pslverr", {32'h0000_0000, er}, {32'h0000_0000, e});
   endtask : rchk

   task pulse_sync;
      @(posedge clk);
      sync_in <= 1'b1;
      @(posedge clk);
      sync_in <= 1'b0;
   endtask : pulse_sync

   // sample driver; valid is lowered only after the last sample is taken
   task push(input int n, input logic [13:0] a, input logic [13:0] b);
      @(posedge clk);
      samp_valid <= 1'b1;
      samp_data  <= {a, b};
      repeat (n)
      begin
         k = 0;
         do
         begin
            @(negedge clk);
            k++;
         end
         while (samp_ready !== 1'b1 && k < 50);
         if (k >= 50)
            tmo("samp_ready");
         @(posedge clk);
      end
      samp_valid <= 1'b0;
   endtask : push

   // two distinct samples after realignment; the later one must survive decimation
   task dtest(input logic [7:0] ctl, input logic [7:0] isel, input logic [7:0] n,
              input logic [32:0] exp);
      apb(1'b1, `DDC_IDX_CTRL, {24'h00_0000, ctl});
      apb(1'b1, `DDC_IDX_INSEL, {24'h00_0000, isel});
      pulse_sync();
      c0 = cnt;
      push(1, 14'h0456, 14'h2123);
      push(1, 14'h2123, 14'h0456);
      for (k = 0; k < 50 && cnt != c0 + n; k++)
         @(negedge clk);
      chk("out count", {25'h000_0000, cnt - c0}, {25'h000_0000, n});
      chk("out word", last, exp);
   endtask : dtest

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rchk("sync reg", `DDC_IDX_SYNC, 32'h0000_0000, 1'b0);
      rchk("ctrl reg", `DDC_IDX_CTRL, 32'h0000_0000, 1'b0);
      rchk("insel reg", `DDC_IDX_INSEL, 32'h0000_0000, 1'b0);
      rchk("status", `DDC_IDX_STAT, 32'h0000_0044, 1'b0);
      rchk("unmapped", 10'h3ff, 32'h0000_0000, 1'b1);
      $display("test reset done");
      // soft reset holds, one-shot arms, one sync frees
      apb(1'b1, `DDC_IDX_SYNC, 32'h0000_0010);
      rchk("nco held", `DDC_IDX_STAT, 32'h0000_0041, 1'b0);
      apb(1'b1, `DDC_IDX_SYNC, 32'h0000_0002);
      rchk("nco armed", `DDC_IDX_STAT, 32'h0000_0042, 1'b0);
      pulse_sync();
      rchk("nco free", `DDC_IDX_STAT, 32'h0000_0044, 1'b0);
      apb(1'b1, `DDC_IDX_SYNC, 32'h0000_0001);
      $display("test nco done");
      // every decimation code, with and without complex-to-real
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, `DDC_IDX_CTRL, {28'h000_0000, i[2], 1'b0, i[1:0]});
         apb(1'b0, `DDC_IDX_STAT, 32'h0000_0000);
         chk("ratio", {28'h000_0000, rd[8:4]}, {28'h000_0000, rt[i[1:0]] >> i[2]});
      end
      $display("test ratio done");
      // quarter turn per sample, so the tunable nco shows in the output
      nco_ftw <= 12'h400;
      dtest(8'h93, 8'h04, 8'h01, {1'b0, 16'he123, 16'h0456});
      dtest(8'h83, 8'h04, 8'h01, {1'b0, 16'h0456, 16'h1edd});
      dtest(8'ha3, 8'h04, 8'h01, {1'b0, 16'h0456, 16'h1edd});
      dtest(8'hd3, 8'h04, 8'h01, {1'b0, 16'hc246, 16'h08ac});
      dtest(8'h93, 8'h01, 8'h01, {1'b0, 16'h0456, 16'he123});
      dtest(8'hb3, 8'h04, 8'h01, {1'b0, 16'h1fff, 16'he001});
      dtest(8'h9b, 8'h04, 8'h02, {1'b1, 16'he123, 16'h0000});
      $display("test datapath done");
      // stalled sink: fill until refused, then drain to empty
      apb(1'b1, `DDC_IDX_CTRL, 32'h0000_0093);
      stall <= 1'b1;
      c0 = cnt;
      @(posedge clk);
      samp_valid <= 1'b1;
      for (k = 0; k < 40 && samp_ready !== 1'b0; k++)
         @(negedge clk);
      chk("refused", {32'h0000_0000, samp_ready}, 33'h0_0000_0000);
      @(posedge clk);
      samp_valid <= 1'b0;
      stall      <= 1'b0;
      for (k = 0; k < 50 && out_valid !== 1'b0; k++)
         @(negedge clk);
      chk("drained", {25'h000_0000, cnt - c0}, 33'h0_0000_0005);
      $display("test buffer done");
      close_out();
   end
endmodule : ddc_sync_and_channel_control_tb
